// file: imp_pkg.sv
// Constants and types shared by the indirect extended-register portal
package imp_pkg;

	// -------------------------------------------------------------------
	// Management register offsets
	// -------------------------------------------------------------------
	localparam logic [4:0]  IMP_OFS_CTRL      = 5'h0D;
	localparam logic [4:0]  IMP_OFS_WINDOW    = 5'h0E;

	// -------------------------------------------------------------------
	// Control register field layout
	// -------------------------------------------------------------------
	localparam int          IMP_OP_MSB        = 15;
	localparam int          IMP_OP_LSB        = 14;
	localparam int          IMP_DEV_MSB       = 4;
	localparam int          IMP_DEV_LSB       = 0;

	// -------------------------------------------------------------------
	// Values after reset, and the held address step
	// -------------------------------------------------------------------
	localparam logic [15:0] IMP_CTRL_RST      = 16'h0000;
	localparam logic [15:0] IMP_ADDR_RST      = 16'h0000;
	localparam logic [15:0] IMP_RDDATA_RST    = 16'h0000;
	localparam logic [15:0] IMP_ADDR_STEP     = 16'h0001;

	// -------------------------------------------------------------------
	// Extended registers held here
	// -------------------------------------------------------------------
	localparam logic [4:0]  IMP_DEV_AUTONEG   = 5'h00;
	localparam logic [15:0] IMP_REG_BURST_LO  = 16'h0003;
	localparam logic [15:0] IMP_REG_BURST_HI  = 16'h0004;
	localparam logic [15:0] IMP_BURST_LO_RST  = 16'h4000;
	localparam logic [15:0] IMP_BURST_HI_RST  = 16'h0003;
	localparam logic [15:0] IMP_BURST_LO_16MS = 16'h1A80;
	localparam logic [15:0] IMP_BURST_HI_16MS = 16'h0006;
	localparam logic [15:0] IMP_UNMAPPED_RD   = 16'h0000;

	// -------------------------------------------------------------------
	// Window usage modes
	// -------------------------------------------------------------------
	typedef enum logic [1:0] {
		IMP_OP_ADDRESS = 2'h0,
		IMP_OP_DATA    = 2'h1,
		IMP_OP_DATA_RW = 2'h2,
		IMP_OP_DATA_WR = 2'h3
	} imp_op_t;

endpackage

// file: imp_ext_regs.sv
// Extended register store for device address 0 (burst interval pair)
`timescale 1ns/10ps
module imp_ext_regs (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Access from the portal
	input  wire logic [4:0]  devSel,
	input  wire logic [15:0] regSel,
	input  wire logic        extWrite,
	input  wire logic [15:0] extWrData,
	output logic      [15:0] extRdData,
	// Stored interval pair
	output logic      [15:0] burstIntervalLow,
	output logic      [15:0] burstIntervalHigh
);
	import imp_pkg::*;

	logic hitLow;
	logic hitHigh;

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	assign hitLow  = (devSel == IMP_DEV_AUTONEG) && (regSel == IMP_REG_BURST_LO);
	assign hitHigh = (devSel == IMP_DEV_AUTONEG) && (regSel == IMP_REG_BURST_HI);

	// ---------------------------------------------------------------
	// Interval pair storage
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			burstIntervalLow <= IMP_BURST_LO_RST;
		end else if (extWrite && hitLow) begin
			burstIntervalLow <= extWrData;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			burstIntervalHigh <= IMP_BURST_HI_RST;
		end else if (extWrite && hitHigh) begin
			burstIntervalHigh <= extWrData;
		end
	end

	// ---------------------------------------------------------------
	// Read mux, unmapped reads as zero
	// ---------------------------------------------------------------
	always_comb begin
		if (hitLow) begin
			extRdData = burstIntervalLow;
		end else if (hitHigh) begin
			extRdData = burstIntervalHigh;
		end else begin
			extRdData = IMP_UNMAPPED_RD;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_LOW_WRITE: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && extWrite && hitLow
		|=> burstIntervalLow == $past(extWrData))
		else $error("low interval register missed a write");

	AST_HIGH_HOLD: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && !(extWrite && hitHigh) |=> $stable(burstIntervalHigh))
		else $error("high interval register changed without a write");

endmodule

// file: imp_portal.sv
// Indirect extended-register portal behind the management register port
`timescale 1ns/10ps
module imp_portal (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Management register port
	input  wire logic [4:0]  mgmtAddr,
	input  wire logic        mgmtWrite,
	input  wire logic        mgmtRead,
	input  wire logic [15:0] mgmtWrData,
	output logic      [15:0] mgmtRdData,
	output logic             mgmtRdValid,
	// Burst interval settings
	output logic      [15:0] burstIntervalLow,
	output logic      [15:0] burstIntervalHigh,
	output logic             burstInterval16ms,
	output logic             burstIntervalValid
);
	import imp_pkg::*;

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [15:0] ctrl_reg;
	logic [15:0] regAddr_reg;
	logic [15:0] regAddr_next;
	logic [15:0] rdData_next;
	logic        rdValid_reg;
	imp_op_t     portalOpSelect;
	logic [4:0]  targetDeviceSelect;
	logic        ctrlHit;
	logic        windowHit;
	logic        windowWrite;
	logic        windowRead;
	logic        dataWrite;
	logic        dataRead;
	logic [15:0] extRdData;
	logic        lowIs8ms;
	logic        lowIs16ms;
	logic        highIs8ms;
	logic        highIs16ms;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic stepsOnRead(input imp_op_t op);
		stepsOnRead = (op == IMP_OP_DATA_RW);
	endfunction

	function automatic logic stepsOnWrite(input imp_op_t op);
		stepsOnWrite = (op == IMP_OP_DATA_RW) || (op == IMP_OP_DATA_WR);
	endfunction

	// ---------------------------------------------------------------
	// Offset decode
	// ---------------------------------------------------------------
	assign ctrlHit     = (mgmtAddr == IMP_OFS_CTRL);
	assign windowHit   = (mgmtAddr == IMP_OFS_WINDOW);
	assign windowWrite = mgmtWrite && windowHit;
	assign windowRead  = mgmtRead && !mgmtWrite && windowHit;

	// ---------------------------------------------------------------
	// Control register fields
	// ---------------------------------------------------------------
	assign portalOpSelect     = imp_op_t'(ctrl_reg[IMP_OP_MSB:IMP_OP_LSB]);
	assign targetDeviceSelect = ctrl_reg[IMP_DEV_MSB:IMP_DEV_LSB];
	assign dataWrite = windowWrite && (portalOpSelect != IMP_OP_ADDRESS);
	assign dataRead  = windowRead && (portalOpSelect != IMP_OP_ADDRESS);

	// ---------------------------------------------------------------
	// Control register, reserved bits kept as read/write
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_reg <= IMP_CTRL_RST;
		end else if (mgmtWrite && ctrlHit) begin
			ctrl_reg <= mgmtWrData;
		end
	end

	// ---------------------------------------------------------------
	// Held register address with post-increment
	// ---------------------------------------------------------------
	always_comb begin
		regAddr_next = regAddr_reg;
		unique case (portalOpSelect)
			IMP_OP_ADDRESS: begin
				if (windowWrite) begin
					regAddr_next = mgmtWrData;
				end
			end
			IMP_OP_DATA: begin
				regAddr_next = regAddr_reg;
			end
			IMP_OP_DATA_RW, IMP_OP_DATA_WR: begin
				if ((dataWrite && stepsOnWrite(portalOpSelect)) ||
				    (dataRead && stepsOnRead(portalOpSelect))) begin
					regAddr_next = regAddr_reg + IMP_ADDR_STEP;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			regAddr_reg <= IMP_ADDR_RST;
		end else begin
			regAddr_reg <= regAddr_next;
		end
	end

	// ---------------------------------------------------------------
	// Extended register store
	// ---------------------------------------------------------------
	imp_ext_regs u_ext_regs (
		.ref_clk           (ref_clk),
		.rst_n             (rst_n),
		.devSel            (targetDeviceSelect),
		.regSel            (regAddr_reg),
		.extWrite          (dataWrite),
		.extWrData         (mgmtWrData),
		.extRdData         (extRdData),
		.burstIntervalLow  (burstIntervalLow),
		.burstIntervalHigh (burstIntervalHigh)
	);

	// ---------------------------------------------------------------
	// Read answer
	// ---------------------------------------------------------------
	always_comb begin
		rdData_next = IMP_RDDATA_RST;
		if (ctrlHit) begin
			rdData_next = ctrl_reg;
		end else if (windowHit) begin
			if (portalOpSelect == IMP_OP_ADDRESS) begin
				rdData_next = regAddr_reg;
			end else begin
				rdData_next = extRdData;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mgmtRdData <= IMP_RDDATA_RST;
		end else if (mgmtRead && !mgmtWrite) begin
			mgmtRdData <= rdData_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdValid_reg <= 1'b0;
		end else begin
			rdValid_reg <= mgmtRead && !mgmtWrite;
		end
	end

	assign mgmtRdValid = rdValid_reg;

	// ---------------------------------------------------------------
	// Burst interval status
	// ---------------------------------------------------------------
	assign lowIs8ms   = (burstIntervalLow == IMP_BURST_LO_RST);
	assign lowIs16ms  = (burstIntervalLow == IMP_BURST_LO_16MS);
	assign highIs8ms  = (burstIntervalHigh == IMP_BURST_HI_RST);
	assign highIs16ms = (burstIntervalHigh == IMP_BURST_HI_16MS);
	assign burstInterval16ms  = lowIs16ms && highIs16ms;
	assign burstIntervalValid = (lowIs8ms && highIs8ms) ||
	                            (lowIs16ms && highIs16ms);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_CTRL_RESET: assert property (
		@(posedge ref_clk)
		!rst_n |=> portalOpSelect == IMP_OP_ADDRESS && targetDeviceSelect == 5'h00)
		else $error("control register not cleared by reset");

	AST_CTRL_WRITE: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && mgmtWrite && mgmtAddr == IMP_OFS_CTRL
		|=> targetDeviceSelect == $past(mgmtWrData[4:0]))
		else $error("device address not taken from control write");

	AST_ADDR_LOAD: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && windowWrite && portalOpSelect == IMP_OP_ADDRESS
		|=> regAddr_reg == $past(mgmtWrData))
		else $error("register address not loaded in address mode");

	AST_ADDR_READBACK: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && windowRead && portalOpSelect == IMP_OP_ADDRESS
		|=> mgmtRdValid && mgmtRdData == $past(regAddr_reg))
		else $error("address mode read did not return held address");

	AST_NO_STEP: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && (windowRead || windowWrite)
		&& portalOpSelect == IMP_OP_DATA
		|=> $stable(regAddr_reg))
		else $error("address moved in data mode without increment");

	AST_STEP_RW: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && (windowRead || windowWrite)
		&& portalOpSelect == IMP_OP_DATA_RW
		|=> regAddr_reg == 16'($past(regAddr_reg) + 16'h0001))
		else $error("address did not step after access in mode 10");

	AST_STEP_WR: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && portalOpSelect == IMP_OP_DATA_WR
		|-> (windowWrite |=> regAddr_reg == 16'($past(regAddr_reg) + 16'h0001))
		and (windowRead |=> $stable(regAddr_reg)))
		else $error("mode 11 stepping wrong");

	AST_CTRL_KEEPS_ADDR: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && mgmtWrite && ctrlHit |=> $stable(regAddr_reg))
		else $error("control write disturbed held address");

	AST_DATA_READ: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && dataRead |=> mgmtRdData == $past(extRdData))
		else $error("data mode read did not return target register");

	AST_UNMAPPED_ZERO: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && dataRead && targetDeviceSelect != IMP_DEV_AUTONEG
		|=> mgmtRdData == 16'h0000)
		else $error("unimplemented device did not read as zero");

	AST_BURST_RESET: assert property (
		@(posedge ref_clk)
		!rst_n |=> burstIntervalLow == 16'h4000 && burstIntervalHigh == 16'h0003
		##0 burstIntervalValid && !burstInterval16ms)
		else $error("burst interval pair wrong after reset");

	AST_BURST_16MS: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		burstInterval16ms |-> burstIntervalHigh == 16'h0006
		&& burstIntervalLow == 16'h1A80)
		else $error("16 ms flag without matching pair");

	AST_RD_STROBE: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n |=> mgmtRdValid == $past(mgmtRead && !mgmtWrite))
		else $error("read answer strobe out of step with requests");

	AST_RD_DATA_HOLD: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && !(mgmtRead && !mgmtWrite) |=> $stable(mgmtRdData))
		else $error("read data changed without a read");

	AST_CTRL_READBACK: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && mgmtRead && !mgmtWrite && ctrlHit
		|=> mgmtRdData == $past(ctrl_reg))
		else $error("control read did not return all sixteen bits");

	AST_OTHER_OFS_ZERO: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && mgmtRead && !mgmtWrite && !ctrlHit && !windowHit
		|=> mgmtRdValid && mgmtRdData == 16'h0000)
		else $error("read of another offset did not answer zero");

	AST_CTRL_HOLD: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && !(mgmtWrite && ctrlHit) |=> $stable(ctrl_reg))
		else $error("control register changed without a write");

	AST_UNMAPPED_DROP: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && dataWrite && targetDeviceSelect != IMP_DEV_AUTONEG
		|=> $stable(burstIntervalLow) && $stable(burstIntervalHigh))
		else $error("absent device write reached interval pair");

	AST_ADDR_IDLE_HOLD: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rst_n && !windowRead && !windowWrite |=> $stable(regAddr_reg))
		else $error("held address moved without a window access");

	AST_PAIR_MIXED: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(lowIs8ms && highIs16ms) || (lowIs16ms && highIs8ms)
		|-> !burstIntervalValid && !burstInterval16ms)
		else $error("mixed interval pair not flagged");

endmodule

// file: imp_mgmt_host.sv
// Station management controller model for the portal's register port
`timescale 1ns/10ps
module imp_mgmt_host (
	// Clock
	input  wire logic        ref_clk,
	// Management register port
	output logic      [4:0]  mgmtAddr,
	output logic             mgmtWrite,
	output logic             mgmtRead,
	output logic      [15:0] mgmtWrData
);
	import imp_pkg::*;
	initial begin
		mgmtAddr   = 5'h00;
		mgmtWrite  = 1'b0;
		mgmtRead   = 1'b0;
		mgmtWrData = 16'h5A5A;
	end
	// ---------------------------------------------------------------
	// Single requests, one per edge
	// ---------------------------------------------------------------
	task automatic acc(input bit w, input bit r, input logic [4:0] a,
		input logic [15:0] d);
		@(posedge ref_clk);
		mgmtWrite  <= w;
		mgmtRead   <= r;
		mgmtAddr   <= a;
		mgmtWrData <= d;
	endtask
	task automatic idle();
		@(posedge ref_clk);
		mgmtWrite  <= 1'b0;
		mgmtRead   <= 1'b0;
		mgmtWrData <= ~mgmtWrData;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		acc(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [4:0] a);
		acc(1'b0, 1'b1, a, ~mgmtWrData);
	endtask
	// ---------------------------------------------------------------
	// Extended register sequences
	// ---------------------------------------------------------------
	task automatic writeExt(input logic [4:0] dev, input logic [15:0] regNum,
		input logic [15:0] val);
		wr(IMP_OFS_CTRL, {11'h000, dev});
		wr(IMP_OFS_WINDOW, regNum);
		wr(IMP_OFS_CTRL, {2'b01, 9'h000, dev});
		wr(IMP_OFS_WINDOW, val);
		idle();
	endtask
	task automatic readRun(input logic [4:0] dev, input logic [15:0] regNum,
		input int n);
		wr(IMP_OFS_CTRL, {11'h000, dev});
		wr(IMP_OFS_WINDOW, regNum);
		wr(IMP_OFS_CTRL, {2'b10, 9'h000, dev});
		repeat (n) rd(IMP_OFS_WINDOW);
		idle();
	endtask
	// Both halves always get the same interval
	task automatic setInterval(input bit slow);
		writeExt(IMP_DEV_AUTONEG, IMP_REG_BURST_LO,
			slow ? IMP_BURST_LO_16MS : IMP_BURST_LO_RST);
		writeExt(IMP_DEV_AUTONEG, IMP_REG_BURST_HI,
			slow ? IMP_BURST_HI_16MS : IMP_BURST_HI_RST);
	endtask
endmodule

// file: indirect_mmd_access_portal_tb_top.sv
// Self-checking bench for the indirect extended-register portal
`timescale 1ns/10ps
module indirect_mmd_access_portal_tb_top;
	import imp_pkg::*;
	// ---------------------------------------------------------------
	// Signals and model state
	// ---------------------------------------------------------------
	logic        ref_clk;
	logic        rst_n;
	logic [4:0]  mgmtAddr;
	logic        mgmtWrite;
	logic        mgmtRead;
	logic [15:0] mgmtWrData;
	logic [15:0] mgmtRdData;
	logic        mgmtRdValid;
	logic [15:0] burstIntervalLow;
	logic [15:0] burstIntervalHigh;
	logic        burstInterval16ms;
	logic        burstIntervalValid;
	logic [31:0] r;
	logic [4:0]  tDev;
	int          miscompares = 0;
	int          compares = 0;
	int          seed = 84;
	int          ctrl, hAddr, lo, hi, lastD, m, dev;
	bit          expV, slowPair, okPair;

	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;

	imp_portal u_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .mgmtAddr(mgmtAddr),
		.mgmtWrite(mgmtWrite), .mgmtRead(mgmtRead),
		.mgmtWrData(mgmtWrData), .mgmtRdData(mgmtRdData),
		.mgmtRdValid(mgmtRdValid), .burstIntervalLow(burstIntervalLow),
		.burstIntervalHigh(burstIntervalHigh),
		.burstInterval16ms(burstInterval16ms),
		.burstIntervalValid(burstIntervalValid)
	);
	imp_mgmt_host u_host (
		.ref_clk(ref_clk), .mgmtAddr(mgmtAddr), .mgmtWrite(mgmtWrite),
		.mgmtRead(mgmtRead), .mgmtWrData(mgmtWrData)
	);

	task automatic chk(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		if (miscompares == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	function automatic int extRd(int d, int a);
		if (d == 0 && a == 3) return lo;
		if (d == 0 && a == 4) return hi;
		return 0;
	endfunction
	// ---------------------------------------------------------------
	// Reference model, compared every cycle
	// ---------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl = 0; hAddr = 0; lastD = 0; expV = 0;
			lo = IMP_BURST_LO_RST; hi = IMP_BURST_HI_RST;
		end else begin
			slowPair = lo == 16'h1A80 && hi == 16'h0006;
			okPair = slowPair || (lo == 16'h4000 && hi == 16'h0003);
			chk("rdValid", {15'h0000, mgmtRdValid}, {15'h0000, expV});
			chk("rdData", mgmtRdData, lastD[15:0]);
			chk("low", burstIntervalLow, lo[15:0]);
			chk("high", burstIntervalHigh, hi[15:0]);
			chk("slow", {15'h0000, burstInterval16ms}, {15'h0000, slowPair});
			chk("pairOk", {15'h0000, burstIntervalValid}, {15'h0000, okPair});
			m = ctrl >> 14;
			dev = ctrl & 31;
			expV = 0;
			if (mgmtWrite) begin
				if (mgmtAddr == IMP_OFS_CTRL) ctrl = mgmtWrData;
				else if (mgmtAddr == IMP_OFS_WINDOW) begin
					if (m == 0) hAddr = mgmtWrData;
					else begin
						if (dev == 0 && hAddr == 3) lo = mgmtWrData;
						if (dev == 0 && hAddr == 4) hi = mgmtWrData;
						if (m >= 2) hAddr = (hAddr + 1) % 65536;
					end
				end
			end else if (mgmtRead) begin
				expV = 1;
				lastD = 0;
				if (mgmtAddr == IMP_OFS_CTRL) lastD = ctrl;
				if (mgmtAddr == IMP_OFS_WINDOW) begin
					lastD = (m == 0) ? hAddr : extRd(dev, hAddr);
					if (m == 2) hAddr = (hAddr + 1) % 65536;
				end
			end
		end
	end
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		u_host.rd(IMP_OFS_CTRL);
		u_host.rd(IMP_OFS_WINDOW);
		u_host.rd(5'h1F);
		u_host.readRun(IMP_DEV_AUTONEG, IMP_REG_BURST_LO, 3);
		u_host.setInterval(1'b1);
		u_host.readRun(IMP_DEV_AUTONEG, IMP_REG_BURST_LO, 2);
		u_host.writeExt(IMP_DEV_AUTONEG, IMP_REG_BURST_HI, 16'h0003);
		u_host.setInterval(1'b0);
		// Every mode, device 0 then an absent device
		for (int k = 0; k < 8; k++) begin
			r = $random(seed);
			tDev = k[2] ? 5'h09 : 5'h00;
			u_host.wr(IMP_OFS_CTRL, {11'h000, tDev});
			u_host.wr(IMP_OFS_WINDOW, 16'h0003);
			u_host.wr(IMP_OFS_CTRL, {k[1:0], r[8:0], tDev});
			u_host.rd(IMP_OFS_WINDOW);
			u_host.wr(IMP_OFS_WINDOW, r[31:16]);
			u_host.rd(IMP_OFS_WINDOW);
			u_host.rd(IMP_OFS_CTRL);
			u_host.wr(IMP_OFS_CTRL, 16'h0000);
			u_host.rd(IMP_OFS_WINDOW);
			u_host.idle();
		end
		// Address counter wrap in both stepping modes
		for (int k = 2; k < 4; k++) begin
			u_host.wr(IMP_OFS_WINDOW, 16'hFFFF);
			u_host.wr(IMP_OFS_CTRL, {k[1:0], 14'h0005});
			u_host.wr(IMP_OFS_WINDOW, 16'h1234);
			u_host.wr(IMP_OFS_CTRL, 16'h0000);
			u_host.rd(IMP_OFS_WINDOW);
		end
		// Random back-to-back traffic with a reset in mid-run
		for (int k = 0; k < 400; k++) begin
			r = $random(seed);
			u_host.acc(r[0], r[1], r[4] ? r[10:6] :
				(r[5] ? IMP_OFS_CTRL : IMP_OFS_WINDOW), r[31:16]);
			rst_n <= (k != 200);
		end
		u_host.idle();
		repeat (3) @(posedge ref_clk);
		final_report();
	end
	initial begin
		#1_000_000;
		miscompares++;
		final_report();
	end
endmodule
